/* File: core/tmc_defs.svh */
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
// ****************************************
// Register indices, taken from bus address bits 9:2
// ****************************************
`define TMC_IDX_CTRL_A      8'hA0
`define TMC_IDX_CTRL_B      8'hA1
`define TMC_IDX_CAPTURE     8'hA6
`define TMC_IDX_COMPARE_A   8'hA8
`define TMC_IDX_COUNTER     8'hA4
`define TMC_IDX_STATUS      8'hB0
`define TMC_IDX_MASK        8'hB1
`define TMC_IDX_SHADOW_A    8'hB2
// ****************************************
// Field positions and reset values
// ****************************************
`define TMC_B_FILTER_BIT    7
`define TMC_B_EDGE_BIT      6
`define TMC_B_MODE_HI_MSB   4
`define TMC_B_MODE_HI_LSB   3
`define TMC_B_CLK_MSB       2
`define TMC_A_MODE_LO_MSB   1
`define TMC_B_RW_MASK       8'hDF
`define TMC_A_RW_MASK       8'hF3
`define TMC_CTRL_RESET      8'h00
`define TMC_ST_CAPTURE_BIT  0
`define TMC_ST_OVERFLOW_BIT 1
`define TMC_ST_MASK         8'h03
// ****************************************
// Fixed TOP values and prescaler
// ****************************************
`define TMC_TOP_MAX         16'hFFFF
`define TMC_TOP_8BIT        16'h00FF
`define TMC_TOP_9BIT        16'h01FF
`define TMC_TOP_10BIT       16'h03FF
`define TMC_FILTER_SAMPLES  4
`define TMC_PRESCALE_W      10
`endif

/* File: core/tmc_pkg.sv */
package tmc_pkg;
   typedef enum logic [2:0]
   {
      TMC_UPD_NOW    = 3'b001,
      TMC_UPD_TOP    = 3'b010,
      TMC_UPD_BOTTOM = 3'b100
   } tmc_update_e;
   typedef enum logic [2:0]
   {
      TMC_OVF_MAX    = 3'b001,
      TMC_OVF_TOP    = 3'b010,
      TMC_OVF_BOTTOM = 3'b100
   } tmc_ovf_e;
   typedef enum logic [1:0]
   {
      TMC_DIR_UP   = 2'b01,
      TMC_DIR_DOWN = 2'b10
   } tmc_dir_e;
endpackage

/* File: core/tmc_timer.sv */
// Chosen here: the Wishbone interface to the registers.
`include "tmc_defs.svh"
// Behaviour
// - Four mode bits pick counting mode
// - Lower mode bits keep legacy placement
// - Control B: filter, edge, mode hi, clock
// - Mode low bits in control A 1:0
// - Filter enable filters capture pin
// - Filter needs four equal new samples
// - Filtered capture four cycles later
// - Edge select zero falling, one rising
// - Capture copies counter into capture value
// - Capture sets flag; interrupt when enabled
// - Capture disabled when it is TOP
// - Clock code zero stops counter
// - Codes 1-5 divide by 1..1024
// - Codes 6,7 external pin falling/rising
module tmc_timer
   import tmc_pkg::*;
#(
   parameter int FILTER_SAMPLES = `TMC_FILTER_SAMPLES
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Pins
   input  wire logic        capture_pin_i,
   input  wire logic        ext_clock_pin_i,
   // Status
   output logic [15:0]      counter_o,
   output logic             irq_o
);

   // Filter history needs at least one stored sample
   if (FILTER_SAMPLES < 2 || FILTER_SAMPLES > 8)
   begin : g_bad_filter
      $error("FILTER_SAMPLES out of range");
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]  ctrl_a_reg;
   logic [7:0]  ctrl_b_reg;
   logic [15:0] capture_value_reg;
   logic [15:0] compare_a_value_reg;
   logic [15:0] compare_a_shadow_reg;
   logic [15:0] count_reg;
   logic [1:0]  status_reg;
   logic [1:0]  mask_reg;
   tmc_dir_e    dir_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        err_reg;

   // Mode formed from both control registers
   // upper/lower concatenation
   logic [3:0] waveform_mode_sel;
   assign waveform_mode_sel = {ctrl_b_reg[`TMC_B_MODE_HI_MSB:`TMC_B_MODE_HI_LSB],
                               ctrl_a_reg[`TMC_A_MODE_LO_MSB:0]};
   logic       capture_noise_filter_en;
   logic       capture_edge_sel;
   logic [2:0] clock_source_sel;
   assign capture_noise_filter_en = ctrl_b_reg[`TMC_B_FILTER_BIT];
   assign capture_edge_sel        = ctrl_b_reg[`TMC_B_EDGE_BIT];
   assign clock_source_sel        = ctrl_b_reg[`TMC_B_CLK_MSB:0];

   // ****************************************
   // Mode decode
   // ****************************************
   // mode to TOP
   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ocr,
                                          input logic [15:0] icr);
      case (m)
         4'h1, 4'h5: top_of = `TMC_TOP_8BIT;
         4'h2, 4'h6: top_of = `TMC_TOP_9BIT;
         4'h3, 4'h7: top_of = `TMC_TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: top_of = ocr;
         4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
         default: top_of = `TMC_TOP_MAX;
      endcase
   endfunction

   function automatic tmc_update_e upd_of(input logic [3:0] m);
      case (m)
         4'h0, 4'h4, 4'hC, 4'hD: upd_of = TMC_UPD_NOW;
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: upd_of = TMC_UPD_TOP;
         default: upd_of = TMC_UPD_BOTTOM;
      endcase
   endfunction

   function automatic tmc_ovf_e ovf_of(input logic [3:0] m);
      case (m)
         4'h0, 4'h4, 4'hC, 4'hD: ovf_of = TMC_OVF_MAX;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: ovf_of = TMC_OVF_TOP;
         default: ovf_of = TMC_OVF_BOTTOM;
      endcase
   endfunction

   logic [15:0] top;
   tmc_update_e upd_mode;
   tmc_ovf_e    ovf_mode;
   logic        dual_slope;
   logic        clears_at_top;
   logic        icr_is_top;
   assign top           = top_of(waveform_mode_sel, compare_a_value_reg, capture_value_reg);
   assign upd_mode      = upd_of(waveform_mode_sel);
   assign ovf_mode      = ovf_of(waveform_mode_sel);
   assign dual_slope    = (ovf_mode == TMC_OVF_BOTTOM);
   assign clears_at_top = (waveform_mode_sel != 4'h0) && (waveform_mode_sel != 4'hD);
   assign icr_is_top    = (waveform_mode_sel == 4'h8) || (waveform_mode_sel == 4'hA)
                       || (waveform_mode_sel == 4'hC) || (waveform_mode_sel == 4'hE);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] cap_sync_reg;
   logic [1:0] ext_sync_reg;
   logic       ext_prev_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cap_sync_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
         ext_prev_reg <= 1'b0;
      end
      else
      begin
         cap_sync_reg <= {cap_sync_reg[0], capture_pin_i};
         ext_sync_reg <= {ext_sync_reg[0], ext_clock_pin_i};
         ext_prev_reg <= ext_sync_reg[1];
      end
   end

   // ****************************************
   // Prescaler and clock select
   // ****************************************
   logic [`TMC_PRESCALE_W-1:0] presc_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         presc_reg <= '0;
      else
         presc_reg <= presc_reg + 1'b1;
   end

   logic count_en;
   always_comb
   begin
      case (clock_source_sel)
         3'h0: count_en = 1'b0;
         3'h1: count_en = 1'b1;
         3'h2: count_en = (presc_reg[2:0] == 3'h7);
         3'h3: count_en = (presc_reg[5:0] == 6'h3F);
         3'h4: count_en = (presc_reg[7:0] == 8'hFF);
         3'h5: count_en = (presc_reg == 10'h3FF);
         3'h6: count_en = ext_prev_reg & ~ext_sync_reg[1];
         default: count_en = ~ext_prev_reg & ext_sync_reg[1];
      endcase
   end

   // ****************************************
   // Capture filter and edge detect
   // ****************************************
   // Samples shifted past the second sync stage only
   logic [FILTER_SAMPLES-2:0] hist_reg;
   logic [FILTER_SAMPLES-1:0] win;
   logic                      filt_reg;
   logic                      cap_prev_reg;
   logic                      cap_src;
   // Newest synced sample joins the stored history
   assign win = {hist_reg, cap_sync_reg[1]};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hist_reg     <= '0;
         filt_reg     <= 1'b0;
         cap_prev_reg <= 1'b0;
      end
      else
      begin
         hist_reg <= win[FILTER_SAMPLES-2:0];
         if (&win)
            filt_reg <= 1'b1;
         else if (~|win)
            filt_reg <= 1'b0;
         cap_prev_reg <= cap_src;
      end
   end
   assign cap_src = capture_noise_filter_en ? filt_reg : cap_sync_reg[1];

   logic capture_event;
   assign capture_event = ~icr_is_top && (capture_edge_sel ? (cap_src & ~cap_prev_reg)
                                                           : (~cap_src & cap_prev_reg));

   // ****************************************
   // Bus decode
   // ****************************************
   logic [7:0] idx;
   logic       req;
   logic       wr;
   logic       hit;
   assign idx = wb_adr_i[9:2];
   // Error answers block a second take like ack does
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   assign wr  = req & wb_we_i;
   always_comb
   begin
      case (idx)
         `TMC_IDX_CTRL_A, `TMC_IDX_CTRL_B, `TMC_IDX_CAPTURE, `TMC_IDX_COMPARE_A,
         `TMC_IDX_COUNTER, `TMC_IDX_STATUS, `TMC_IDX_MASK, `TMC_IDX_SHADOW_A: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   logic [15:0] wdata16;
   assign wdata16 = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};

   // ****************************************
   // Counter
   // ****************************************
   logic at_top;
   logic at_bottom;
   assign at_top    = (count_reg == top);
   assign at_bottom = (count_reg == 16'h0000);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_reg <= 16'h0000;
         dir_reg   <= TMC_DIR_UP;
      end
      else if (wr && idx == `TMC_IDX_COUNTER && wb_sel_i[0])
         count_reg <= wdata16;
      else if (count_en)
      begin
         if (dual_slope)
         begin
            if (dir_reg == TMC_DIR_UP && at_top)
            begin
               dir_reg   <= TMC_DIR_DOWN;
               count_reg <= count_reg - 16'h0001;
            end
            else if (dir_reg == TMC_DIR_DOWN && at_bottom)
            begin
               dir_reg   <= TMC_DIR_UP;
               count_reg <= count_reg + 16'h0001;
            end
            else if (dir_reg == TMC_DIR_UP)
               count_reg <= count_reg + 16'h0001;
            else
               count_reg <= count_reg - 16'h0001;
         end
         else if (clears_at_top && at_top)
            count_reg <= 16'h0000;
         else
            count_reg <= count_reg + 16'h0001;
      end
   end
   assign counter_o = count_reg;

   // ****************************************
   // Compare A and capture value
   // ****************************************
   logic upd_now;
   assign upd_now = (upd_mode == TMC_UPD_NOW)
                 || (count_en && upd_mode == TMC_UPD_TOP && at_top)
                 || (count_en && upd_mode == TMC_UPD_BOTTOM && at_bottom);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         compare_a_shadow_reg <= 16'h0000;
         compare_a_value_reg  <= 16'h0000;
      end
      else
      begin
         if (wr && idx == `TMC_IDX_COMPARE_A && wb_sel_i[0])
            compare_a_shadow_reg <= wdata16;
         if (upd_now)
            compare_a_value_reg <= compare_a_shadow_reg;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         capture_value_reg <= 16'h0000;
      else if (capture_event)
         capture_value_reg <= count_reg;
      else if (wr && idx == `TMC_IDX_CAPTURE && wb_sel_i[0])
         capture_value_reg <= wdata16;
   end

   // ****************************************
   // Control registers
   // ****************************************
   // legacy bit placement kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_a_reg <= `TMC_CTRL_RESET;
         ctrl_b_reg <= `TMC_CTRL_RESET;
      end
      else if (wr && wb_sel_i[0])
      begin
         if (idx == `TMC_IDX_CTRL_A)
            ctrl_a_reg <= wb_dat_i[7:0] & `TMC_A_RW_MASK;
         if (idx == `TMC_IDX_CTRL_B)
            ctrl_b_reg <= wb_dat_i[7:0] & `TMC_B_RW_MASK;
      end
   end

   // ****************************************
   // Flags and interrupt
   // ****************************************
   logic ovf_event;
   assign ovf_event = count_en && ((ovf_mode == TMC_OVF_MAX && count_reg == `TMC_TOP_MAX)
                   || (ovf_mode == TMC_OVF_TOP && at_top)
                   || (ovf_mode == TMC_OVF_BOTTOM && at_bottom && dir_reg == TMC_DIR_DOWN));
   logic [1:0] set_bits;
   logic [1:0] clr_bits;
   assign set_bits = {ovf_event, capture_event};
   assign clr_bits = (wr && idx == `TMC_IDX_STATUS && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_reg <= 2'h0;
      else
         status_reg <= (status_reg & ~clr_bits) | set_bits;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_reg <= 2'h0;
      else if (wr && idx == `TMC_IDX_MASK && wb_sel_i[0])
         mask_reg <= wb_dat_i[1:0];
   end
   assign irq_o = |(status_reg & mask_reg);

   // ****************************************
   // Bus answer
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= req & hit;
         err_reg <= req & ~hit;
         case (idx)
            `TMC_IDX_CTRL_A:    rdata_reg <= {24'h0, ctrl_a_reg};
            `TMC_IDX_CTRL_B:    rdata_reg <= {24'h0, ctrl_b_reg};
            `TMC_IDX_CAPTURE:   rdata_reg <= {16'h0, capture_value_reg};
            `TMC_IDX_COMPARE_A: rdata_reg <= {16'h0, compare_a_value_reg};
            `TMC_IDX_COUNTER:   rdata_reg <= {16'h0, count_reg};
            `TMC_IDX_STATUS:    rdata_reg <= {30'h0, status_reg};
            `TMC_IDX_MASK:      rdata_reg <= {30'h0, mask_reg};
            `TMC_IDX_SHADOW_A:  rdata_reg <= {16'h0, compare_a_shadow_reg};
            default:            rdata_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdata_reg;

endmodule

/* File: verif/tmc_timer_properties.sv */
module tmc_timer_properties
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   // Status
   input wire logic [15:0] counter_o
);
   logic [7:0] idx;
   logic       req;
   logic [2:0] csel;
   logic [3:0] mode;
   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   function automatic logic hit(input logic [7:0] i);
      return i inside {8'hA0, 8'hA1, 8'hA4, 8'hA6, 8'hA8, 8'hB0, 8'hB1, 8'hB2};
   endfunction
   // Shadow of clock and mode fields, seen from bus writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         csel <= 3'h0;
         mode <= 4'h0;
      end
      else if (req && wb_we_i && wb_sel_i[0])
      begin
         if (idx == 8'hA1)
         begin
            csel      <= wb_dat_i[2:0];
            mode[3:2] <= wb_dat_i[4:3];
         end
         if (idx == 8'hA0)
            mode[1:0] <= wb_dat_i[1:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      req;
   endsequence
   sequence s_idle;
      !wb_cyc_i;
   endsequence
   a_answer_next: assert property (s_take |=> wb_ack_o || wb_err_o)
      else $error("request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_spurious: assert property (!req |=> !wb_ack_o && !wb_err_o)
      else $error("answer without request");
   a_err_unmapped: assert property (s_take and !hit(idx) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   a_ack_mapped: assert property (s_take and hit(idx) |=> wb_ack_o && !wb_err_o)
      else $error("mapped access not acked");
   a_ctrl_b_read: assert property (s_take and !wb_we_i && idx == 8'hA1 |=>
      wb_dat_o[31:8] == 24'h0 && !wb_dat_o[5]) else $error("control b unused bits set");
   // Slack of two cycles for the tick pipeline
   a_stop_hold: assert property (s_idle and csel == 3'h0 && $past(csel) == 3'h0
      && $past(csel, 2) == 3'h0 |=> $stable(counter_o)) else $error("stopped counter moved");
   a_fixed_top: assert property (s_idle and !mode[3] && mode[1:0] == 2'h1
      && counter_o <= 16'h00FF |=> counter_o <= 16'h00FF) else $error("8-bit top exceeded");
endmodule
bind tmc_timer tmc_timer_properties tmc_timer_properties_inst (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
   .counter_o);

/* File: verif/tmc_timer_test.sv */
module tmc_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Stimulus and checking
   // ****************************************
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic        cap   = 1'b0;
   logic        ext   = 1'b0;
   logic [9:0]  adr   = 10'h000;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] dat   = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        ack;
   logic        err;
   logic        irq;
   logic        e_seen;
   logic [15:0] cnt;
   logic [15:0] c0;
   logic [15:0] mx;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n0;
   int          n1;
   int          dv[5] = '{1, 8, 64, 256, 1024};
   logic [3:0]  md[14] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB,
                           4'hC, 4'hE, 4'hF};
   logic [15:0] tp[14] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0030, 16'h00FF, 16'h01FF, 16'h03FF,
                           16'h0050, 16'h0030, 16'h0050, 16'h0030, 16'h0050, 16'h0050, 16'h0030};
   tmc_timer tmc_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .capture_pin_i(cap), .ext_clock_pin_i(ext),
      .counter_o(cnt), .irq_o(irq));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   task wrap_up;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until the answer edge
   task xfer(input logic [7:0] i, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= {i, 2'b00};
      sel <= 4'hF;
      dat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e_seen = err;
      cyc <= 1'b0;
      we  <= 1'b0;
      // Request edge, take edge, then the answer edge
      chk("answer cycles", 32'd2, 32'(n));
   endtask
   task rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
      xfer(i, 1'b0, 32'h0);
      chk(nm, e, q);
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task meas(output int n);
      n = 0;
      cap <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (irq !== 1'b1 && n < 40);
   endtask
   initial
   begin
      tick(6);
      rst_i <= 1'b0;
      rdc("ctrl_a reset", 8'hA0, 32'h0);
      rdc("ctrl_b reset", 8'hA1, 32'h0);
      xfer(8'hA1, 1'b1, 32'hFF);
      rdc("ctrl_b fields", 8'hA1, 32'hDF);
      xfer(8'hA0, 1'b1, 32'h03);
      rdc("ctrl_a mode", 8'hA0, 32'h03);
      xfer(8'hC0, 1'b0, 32'h0);
      chk("unmapped err", 1'b1, e_seen);
      xfer(8'hA0, 1'b1, 32'h0);
      xfer(8'hA1, 1'b1, 32'h0);
      xfer(8'hA4, 1'b1, 32'h0);
      c0 = cnt;
      tick(100);
      chk("stopped", c0, cnt);
      for (int k = 0; k < 5; k++)
      begin
         xfer(8'hA1, 1'b1, 32'(k + 1));
         c0 = cnt;
         tick(16 * dv[k]);
         c0 = cnt - c0;
         chk("prescale", 1'b1, c0 >= 16'd15 && c0 <= 16'd17);
      end
      for (int k = 6; k < 8; k++)
      begin
         ext <= k[0];
         xfer(8'hA1, 1'b1, 32'(k));
         tick(8);
         c0 = cnt;
         ext <= ~k[0];
         tick(8);
         chk("ext other edge", c0, cnt);
         ext <= k[0];
         tick(8);
         chk("ext count edge", 16'(c0 + 16'h1), cnt);
      end
      xfer(8'hA1, 1'b1, 32'h0);
      xfer(8'hA4, 1'b1, 32'h1234);
      xfer(8'hB0, 1'b1, 32'h3);
      xfer(8'hB1, 1'b1, 32'h1);
      xfer(8'hA1, 1'b1, 32'h40);
      meas(n0);
      rdc("capture value", 8'hA6, 32'h1234);
      rdc("capture flag", 8'hB0, 32'h1);
      xfer(8'hB0, 1'b1, 32'h1);
      tick(2);
      chk("irq cleared", 1'b0, irq);
      cap <= 1'b0;
      tick(10);
      chk("falling ignored", 1'b0, irq);
      xfer(8'hB1, 1'b1, 32'h0);
      xfer(8'hA1, 1'b1, 32'h0);
      cap <= 1'b1;
      tick(10);
      rdc("rising ignored", 8'hB0, 32'h0);
      cap <= 1'b0;
      tick(10);
      chk("masked irq", 1'b0, irq);
      rdc("falling flag", 8'hB0, 32'h1);
      xfer(8'hB0, 1'b1, 32'h1);
      xfer(8'hB1, 1'b1, 32'h1);
      xfer(8'hA1, 1'b1, 32'h40);
      meas(n0);
      cap <= 1'b0;
      tick(12);
      xfer(8'hB0, 1'b1, 32'h1);
      xfer(8'hA1, 1'b1, 32'hC0);
      tick(10);
      meas(n1);
      chk("filter delay", n0 + 4, n1);
      cap <= 1'b0;
      tick(12);
      xfer(8'hB0, 1'b1, 32'h1);
      cap <= 1'b1;
      tick(3);
      cap <= 1'b0;
      tick(12);
      chk("short pulse", 1'b0, irq);
      xfer(8'hA1, 1'b1, 32'h50);
      cap <= 1'b1;
      tick(12);
      chk("capture as top", 1'b0, irq);
      cap <= 1'b0;
      // Mode 13 is reserved and left out of the sweep
      for (int k = 0; k < 14; k++)
      begin
         xfer(8'hA1, 1'b1, 32'h0);
         xfer(8'hA4, 1'b1, 32'h0);
         xfer(8'hA6, 1'b1, 32'h50);
         xfer(8'hB0, 1'b1, 32'h3);
         xfer(8'hA0, 1'b1, 32'(md[k][1:0]));
         xfer(8'hA1, 1'b1, 32'({md[k][3:2], 3'h1}));
         xfer(8'hA8, 1'b1, 32'h30);
         mx = 16'h0;
         // Three TOP spans cover a full up and down sweep
         repeat (3 * tp[k] + 16)
         begin
            @(posedge clk_i);
            if (cnt > mx)
               mx = cnt;
         end
         chk("top", tp[k], mx);
         // Modes 4 and C clear on match and flag only at MAX
         if (md[k] != 4'h4 && md[k] != 4'hC)
            rdc("overflow flag", 8'hB0, 32'h2);
      end
      wrap_up();
   end
endmodule
